// ==== rtl/pid_regulator.sv ====
// Process regulator with sleep and wake supervisor for a motor drive.
// Assumes one 50 MHz clock, AXI4-Lite registers, and a feedback sample
// produced on the same clock; the sleep command pin is asynchronous.
//
// Behaviour
// - Error is setpoint minus feedback each cycle.
// - Proportional term is gain times error.
// - Longer integral time slows integral accumulation.
// - Mode bit 0 enables; clear leaves reference untouched.
// - Mode 0001b raises speed when feedback low.
// - Mode 0011b inverts action, slowing when low.
// - Mode bit 2 picks derivative input.
// - Mode bit 3 adds setpoint to output.
// - Regulator drives reference only for source 5.
// - Feedback code 1 voltage, 2 current.
// - Sleep mode 0 off, 1 level-and-delay.
// - Sleep mode 2 follows digital input.
// - Sleep after output below level for delay.
// - Wake after output above level for delay.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
module pid_regulator #(
  parameter int TICK_CYC = pid_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transducer sample, full scale 4095, and sleep command pin.
  input wire logic [11:0] feedbackRaw,
  input wire logic sleepCmdPin,
  // Reference from the other frequency command source.
  input wire logic [11:0] freqRefIn,
  // Frequency reference and output enable towards the drive.
  output logic [11:0] freqRefOut,
  output logic outputOn
);

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  logic [3:0] mode_reg;        // Regulator mode word.
  logic [1:0] sleepSel_reg;    // Sleep mode selection.
  logic [1:0] fbSel_reg;       // Feedback source selection.
  logic [3:0] freqSrc_reg;     // Main frequency source selection.
  logic [11:0] setpoint_reg;   // Setpoint, percent of full scale.
  logic [11:0] kp_reg;         // Proportional gain, 8 fraction bits.
  logic [15:0] ti_reg;         // Integral time in ms, zero stops it.
  logic [11:0] kd_reg;         // Derivative gain, 8 fraction bits.
  logic [11:0] sleepLvl_reg;   // Sleep level, percent.
  logic [15:0] sleepDly_reg;   // Sleep delay, ms.
  logic [11:0] wakeLvl_reg;    // Wake-up level, percent.
  logic [15:0] wakeDly_reg;    // Wake-up delay, ms.

  // ****************************************************************
  // AXI4-Lite slave.
  // ****************************************************************
  logic awHeld_reg;            // Write address accepted and held.
  logic wHeld_reg;             // Write data accepted and held.
  logic [7:0] awAddr_reg;      // Held write address.
  logic [31:0] wData_reg;      // Held write data.
  logic [3:0] wStrb_reg;       // Held byte strobes.
  logic bValid_reg;            // Write response pending.
  logic [1:0] bResp_reg;       // Write response code.
  logic rValid_reg;            // Read data pending.
  logic [31:0] rData_reg;      // Read data.
  logic [1:0] rResp_reg;       // Read response code.

  // Each write channel is taken on its own while its holding slot is free and no write response is pending.
  wire awTake = s_axi_awvalid && !awHeld_reg && !bValid_reg;
  wire wTake = s_axi_wvalid && !wHeld_reg && !bValid_reg;
  wire wrDo = awHeld_reg && wHeld_reg && !bValid_reg;
  wire arTake = s_axi_arvalid && !rValid_reg;

  // Write decode on the held address.
  wire wrAddrOk = (awAddr_reg <= pid_pkg::OFS_WDLY) &&
                  (awAddr_reg[1:0] == 2'h0);
  wire [15:0] wLow = {wStrb_reg[1] ? wData_reg[15:8] : 8'h00,
                      wStrb_reg[0] ? wData_reg[7:0] : 8'h00};
  wire wrLowEn = wrDo && wrAddrOk && wStrb_reg[0];

  // The valid, response and read data outputs are registered copies of the slot state below.
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;

  // Holding slots and the write response.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg <= pid_pkg::RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (awTake) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (wTake) begin
        wHeld_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrDo) begin
        // Both halves present: commit and answer.
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bValid_reg <= 1'b1;
        bResp_reg <= wrAddrOk ? pid_pkg::RESP_OKAY : pid_pkg::RESP_SLVERR;
      end else if (bValid_reg && s_axi_bready) begin
        // Both slots are empty once the response is taken.
        bValid_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register writes; fields wider than a byte also use lane 1.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_reg <= pid_pkg::RST_MODE;
      sleepSel_reg <= pid_pkg::RST_SLEEP;
      fbSel_reg <= pid_pkg::RST_FBSEL;
      freqSrc_reg <= pid_pkg::RST_FSRC;
      setpoint_reg <= 12'h000;
      kp_reg <= pid_pkg::RST_KP;
      ti_reg <= pid_pkg::RST_TI;
      kd_reg <= 12'h000;
      sleepLvl_reg <= 12'h000;
      sleepDly_reg <= pid_pkg::RST_DLY;
      wakeLvl_reg <= 12'h000;
      wakeDly_reg <= pid_pkg::RST_DLY;
    end else if (wrLowEn) begin
      case (awAddr_reg)
        pid_pkg::OFS_MODE: mode_reg <= wLow[3:0];
        pid_pkg::OFS_SLEEP: sleepSel_reg <= wLow[1:0];
        pid_pkg::OFS_FBSEL: fbSel_reg <= wLow[1:0];
        pid_pkg::OFS_FSRC: freqSrc_reg <= wLow[3:0];
        pid_pkg::OFS_SETP: setpoint_reg <= wLow[11:0];
        pid_pkg::OFS_KP: kp_reg <= wLow[11:0];
        pid_pkg::OFS_TI: ti_reg <= wLow;
        pid_pkg::OFS_KD: kd_reg <= wLow[11:0];
        pid_pkg::OFS_SLVL: sleepLvl_reg <= wLow[11:0];
        pid_pkg::OFS_SDLY: sleepDly_reg <= wLow;
        pid_pkg::OFS_WLVL: wakeLvl_reg <= wLow[11:0];
        pid_pkg::OFS_WDLY: wakeDly_reg <= wLow;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Feedback conditioning.
  // ****************************************************************
  // Code 2 removes the 4 mA live zero and stretches by 5/4.
  wire [14:0] curSpan = 15'(feedbackRaw - pid_pkg::LIVE_ZERO) * 15'd5;
  wire [12:0] curPct = curSpan[14:2];
  wire [11:0] curClip = (feedbackRaw < pid_pkg::LIVE_ZERO) ? 12'h000 :
                        (curPct > 13'(pid_pkg::PCT_FULL)) ?
                        pid_pkg::PCT_FULL : curPct[11:0];
  wire [11:0] fbPct = (fbSel_reg == pid_pkg::FB_CURR) ? curClip :
                      feedbackRaw;

  // ****************************************************************
  // Sample tick and sleep command synchroniser.
  // ****************************************************************
  logic [$clog2(TICK_CYC)-1:0] tickCnt_reg; // Cycles in the period.
  logic tick_reg;                           // One-cycle sample strobe.
  logic [2:0] slpSync_reg;                  // Pin synchroniser.
  logic sleepCmd_reg;                       // Qualified pin level.
  // Last cycle of the period, so the strobe repeats every TICK_CYC.
  wire tickWrap = (tickCnt_reg == ($clog2(TICK_CYC))'(TICK_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tickCnt_reg <= '0;
      tick_reg <= 1'b0;
      slpSync_reg <= 3'h0;
      sleepCmd_reg <= 1'b0;
    end else begin
      tick_reg <= tickWrap;
      tickCnt_reg <= tickWrap ? '0 : tickCnt_reg + 1'b1;
      slpSync_reg <= {slpSync_reg[1:0], sleepCmdPin};
      // A change counts once the second and third stages agree.
      if (slpSync_reg[1] == slpSync_reg[2]) begin
        sleepCmd_reg <= slpSync_reg[2];
      end
    end
  end

  // ****************************************************************
  // Regulator arithmetic.
  // ****************************************************************
  logic signed [19:0] integ_reg;   // Integral accumulator.
  logic signed [12:0] dPrev_reg;   // Previous derivative input.
  logic [15:0] tiCnt_reg;          // Ticks since last integration.
  logic [11:0] pidOut_reg;         // Clamped regulator output.
  logic asleep_reg;                // Drive output switched off.

  wire en = mode_reg[pid_pkg::MODE_EN];
  // Error, inverted for the negative characteristic.
  wire signed [12:0] errRaw = $signed({1'b0, setpoint_reg}) -
                              $signed({1'b0, fbPct});
  wire signed [12:0] err = mode_reg[pid_pkg::MODE_NEG] ?
                           -errRaw : errRaw;
  wire signed [24:0] pProd = err * $signed({1'b0, kp_reg});
  wire signed [19:0] pTerm = 20'(pProd >>> pid_pkg::GAIN_FRAC);
  // Derivative input: error, or feedback with the sign it has in the error.
  wire signed [12:0] fbSigned = $signed({1'b0, fbPct});
  wire signed [12:0] dIn = mode_reg[pid_pkg::MODE_DFB] ?
                           (mode_reg[pid_pkg::MODE_NEG] ?
                            fbSigned : -fbSigned) : err;
  wire signed [13:0] dDelta = 14'(dIn) - 14'(dPrev_reg);
  wire signed [25:0] dProd = dDelta * $signed({1'b0, kd_reg});
  wire signed [19:0] dTerm = 20'(dProd >>> pid_pkg::GAIN_FRAC);
  // The integral advances by Kp*err once per integral time.
  wire integStep = tick_reg && (ti_reg != 16'h0000) &&
                   (tiCnt_reg + 1'b1 >= ti_reg);
  wire signed [20:0] integSum = 21'(integ_reg) + 21'(pTerm);
  wire signed [20:0] pctFull21 = 21'(pid_pkg::PCT_FULL);
  wire signed [19:0] integClip = (integSum < 0) ? 20'sd0 :
                                 (integSum > pctFull21) ?
                                 20'(pid_pkg::PCT_FULL) :
                                 integSum[19:0];
  // Sum of terms, optionally offset by the target, then clamped.
  wire signed [21:0] sum = 22'(pTerm) + 22'(integ_reg) + 22'(dTerm) +
                           (mode_reg[pid_pkg::MODE_ADD] ?
                            22'(setpoint_reg) : 22'sd0);
  wire [11:0] sumClip = (sum < 0) ? 12'h000 :
                        (sum > 22'(pid_pkg::PCT_FULL)) ?
                        pid_pkg::PCT_FULL : sum[11:0];

  // Regulator state updates once per sample period while enabled; while disabled it is cleared every cycle, except dPrev_reg, which follows dIn.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      integ_reg <= 20'sd0;
      dPrev_reg <= 13'sd0;
      tiCnt_reg <= 16'h0000;
      pidOut_reg <= 12'h000;
    end else if (!en) begin
      integ_reg <= 20'sd0;
      dPrev_reg <= dIn;
      tiCnt_reg <= 16'h0000;
      pidOut_reg <= 12'h000;
    end else if (tick_reg) begin
      dPrev_reg <= dIn;
      pidOut_reg <= sumClip;
      tiCnt_reg <= integStep ? 16'h0000 : tiCnt_reg + 1'b1;
      if (integStep) begin
        integ_reg <= integClip;
      end
    end
  end

  // ****************************************************************
  // Sleep and wake supervisor.
  // ****************************************************************
  wire sleepLow = (pidOut_reg < sleepLvl_reg);
  wire wakeHigh = (pidOut_reg > wakeLvl_reg);
  wire sleepDone;
  wire wakeDone;

  // Sleep entry qualifier; runs only while awake.
  pid_delay_timer #(.DLY_W(16)) sleepTimer (
    .clk(clk),
    .rst_n(rst_n),
    .cond(sleepLow && !asleep_reg),
    .tick(tick_reg),
    .delayTicks(sleepDly_reg),
    .done(sleepDone)
  );

  // Wake-up qualifier; runs only while asleep.
  pid_delay_timer #(.DLY_W(16)) wakeTimer (
    .clk(clk),
    .rst_n(rst_n),
    .cond(wakeHigh && asleep_reg),
    .tick(tick_reg),
    .delayTicks(wakeDly_reg),
    .done(wakeDone)
  );

  wire pidRef = en && (freqSrc_reg == pid_pkg::FSRC_PID);
  logic asleep_next;
  always_comb begin
    asleep_next = asleep_reg;
    if (!pidRef || sleepSel_reg == pid_pkg::SLP_OFF) begin
      asleep_next = 1'b0;
    end else if (sleepSel_reg == pid_pkg::SLP_DIN) begin
      asleep_next = sleepCmd_reg;
    end else if (sleepSel_reg == pid_pkg::SLP_LVL) begin
      if (!asleep_reg && sleepDone) begin
        asleep_next = 1'b1;
      end else if (asleep_reg && wakeDone) begin
        asleep_next = 1'b0;
      end
    end
  end

  // Drive-side outputs, all from flip-flops.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      asleep_reg <= 1'b0;
      freqRefOut <= 12'h000;
      outputOn <= 1'b1;
    end else begin
      asleep_reg <= asleep_next;
      freqRefOut <= pidRef ? pidOut_reg : freqRefIn;
      outputOn <= !asleep_next;
    end
  end

  // ****************************************************************
  // Read path.
  // ****************************************************************
  logic [31:0] rdMux;
  logic rdOk;
  always_comb begin
    rdOk = 1'b1;
    case (s_axi_araddr)
      pid_pkg::OFS_MODE: rdMux = {28'h0, mode_reg};
      pid_pkg::OFS_SLEEP: rdMux = {30'h0, sleepSel_reg};
      pid_pkg::OFS_FBSEL: rdMux = {30'h0, fbSel_reg};
      pid_pkg::OFS_FSRC: rdMux = {28'h0, freqSrc_reg};
      pid_pkg::OFS_SETP: rdMux = {20'h0, setpoint_reg};
      pid_pkg::OFS_KP: rdMux = {20'h0, kp_reg};
      pid_pkg::OFS_TI: rdMux = {16'h0, ti_reg};
      pid_pkg::OFS_KD: rdMux = {20'h0, kd_reg};
      pid_pkg::OFS_SLVL: rdMux = {20'h0, sleepLvl_reg};
      pid_pkg::OFS_SDLY: rdMux = {16'h0, sleepDly_reg};
      pid_pkg::OFS_WLVL: rdMux = {20'h0, wakeLvl_reg};
      pid_pkg::OFS_WDLY: rdMux = {16'h0, wakeDly_reg};
      pid_pkg::OFS_STAT: rdMux = {fbPct, 16'h0, 2'h0, sleepCmd_reg,
                                  asleep_reg};
      pid_pkg::OFS_OUT: rdMux = {integ_reg[11:0], 8'h00, pidOut_reg};
      default: begin
        rdMux = 32'h0000_0000;
        rdOk = 1'b0;
      end
    endcase
  end

  // Read data is captured on the address handshake.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0000_0000;
      rResp_reg <= pid_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else if (arTake) begin
      rValid_reg <= 1'b1;
      s_axi_arready <= 1'b0;
      rData_reg <= rdMux;
      rResp_reg <= rdOk ? pid_pkg::RESP_OKAY : pid_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_reg <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ==== rtl/pid_pkg.sv ====
// Package of constants for the process regulator with sleep and wake.
// Assumes a 50 MHz control clock and an AXI4-Lite register bus.
package pid_pkg;

  // ****************************************************************
  // Clock and timing.
  // ****************************************************************
  localparam int CLK_HZ = 50000000;          // Control clock rate.
  localparam int TICK_US = 1000;             // Regulator sample period.
  // Cycles per sample period, derived from the clock and the period.
  localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;

  // ****************************************************************
  // Value scaling: 12-bit percentages, 4095 stands for 100 %.
  // ****************************************************************
  localparam int PCT_W = 12;                 // Width of a percentage.
  localparam logic [11:0] PCT_FULL = 12'hfff;  // Full scale.
  localparam logic [11:0] LIVE_ZERO = 12'h333; // 4 mA on the 20 mA span.
  localparam int GAIN_FRAC = 8;              // Fraction bits of gains.

  // ****************************************************************
  // Register offsets (byte addresses).
  // ****************************************************************
  localparam logic [7:0] OFS_MODE = 8'h00;   // regulator_mode_word.
  localparam logic [7:0] OFS_SLEEP = 8'h04;  // sleep_mode_select.
  localparam logic [7:0] OFS_FBSEL = 8'h08;  // Feedback source code.
  localparam logic [7:0] OFS_FSRC = 8'h0c;   // Main frequency source.
  localparam logic [7:0] OFS_SETP = 8'h10;   // Setpoint, percent.
  localparam logic [7:0] OFS_KP = 8'h14;     // Proportional gain.
  localparam logic [7:0] OFS_TI = 8'h18;     // Integral time, ms.
  localparam logic [7:0] OFS_KD = 8'h1c;     // Derivative gain.
  localparam logic [7:0] OFS_SLVL = 8'h20;   // Sleep level, percent.
  localparam logic [7:0] OFS_SDLY = 8'h24;   // Sleep delay, ms.
  localparam logic [7:0] OFS_WLVL = 8'h28;   // Wake-up level, percent.
  localparam logic [7:0] OFS_WDLY = 8'h2c;   // Wake-up delay, ms.
  localparam logic [7:0] OFS_STAT = 8'h30;   // Status, read only.
  localparam logic [7:0] OFS_OUT = 8'h34;    // Regulator output, RO.

  // ****************************************************************
  // Mode word fields and selection codes.
  // ****************************************************************
  localparam int MODE_EN = 0;                // Regulator enable.
  localparam int MODE_NEG = 1;               // Negative characteristic.
  localparam int MODE_DFB = 2;               // Derivative on feedback.
  localparam int MODE_ADD = 3;               // Output plus target.
  localparam logic [3:0] FSRC_PID = 4'h5;    // Regulator reference code.
  localparam logic [1:0] FB_VOLT = 2'h1;     // 0-10 V transducer.
  localparam logic [1:0] FB_CURR = 2'h2;     // 4-20 mA transducer.
  localparam logic [1:0] SLP_OFF = 2'h0;     // Sleep disabled.
  localparam logic [1:0] SLP_LVL = 2'h1;     // Level and delay based.
  localparam logic [1:0] SLP_DIN = 2'h2;     // Digital input commanded.

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [1:0] RST_SLEEP = 2'h0;
  localparam logic [1:0] RST_FBSEL = 2'h1;
  localparam logic [3:0] RST_FSRC = 4'h0;
  localparam logic [11:0] RST_KP = 12'h200;  // Gain 2.0.
  localparam logic [15:0] RST_TI = 16'h1388; // 5000 ms.
  localparam logic [15:0] RST_DLY = 16'h03e8; // 1000 ms.

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== rtl/pid_delay_timer.sv ====
// Qualifying delay timer used for sleep entry and wake-up.
// Assumes a one-cycle sample tick on the same clock as the condition.
module pid_delay_timer #(
  parameter int DLY_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Condition, sample tick and programmed delay in ticks.
  input wire logic cond,
  input wire logic tick,
  input wire logic [DLY_W-1:0] delayTicks,
  // High while the condition has held for the whole delay.
  output logic done
);

  // ****************************************************************
  // Elapsed-time counter.
  // ****************************************************************
  logic [DLY_W-1:0] count_reg; // Ticks the condition has held.
  logic [DLY_W-1:0] count_next;
  wire reached = (count_reg >= delayTicks);

  // The count restarts from zero the moment the condition lapses.
  assign count_next = !cond ? '0 :
                      (tick && !reached) ? count_reg + 1'b1 : count_reg;

  // Done only while the condition still holds.
  assign done = cond && reached;

  // Counter register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// ==== tb/pid_regulator_props.sv ====
// Checker on the bus handshakes and the drive enable of the regulator.
// Assumes a bind to pid_regulator, one clock and a low active reset.
module pid_regulator_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Bus handshakes and read data.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Drive enable.
  input wire logic outputOn
);
  // All checks share the control clock and rest during reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before its handshake");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before its handshake");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while an answer waits");
  a_ar_open: assert property (!s_axi_rvalid |-> s_axi_arready)
    else $error("read address refused while idle");
  a_w_blocked: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while a response waits");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not on the second edge");
  a_reset_on: assert property ($rose(rst_n) |-> outputOn)
    else $error("drive enable low after reset");
endmodule

bind pid_regulator pid_regulator_props pid_regulator_props_i (.*);

// ==== tb/pid_transducer_model.sv ====
// Feedback transducer that turns a process value into the input sample.
// Assumes the process value is full scale at 4095.
module pid_transducer_model (
  // Process value and transducer type.
  input wire logic [11:0] processPct,
  input wire logic currentLoop,
  // Sample seen at the feedback input.
  output logic [11:0] feedbackRaw
);
  // A current loop sits on a 4 mA live zero and spans four fifths.
  assign feedbackRaw = currentLoop ?
    12'(32'(processPct) * 4 / 5 + 32'(pid_pkg::LIVE_ZERO)) :
    processPct;
endmodule

// ==== tb/tb_pid_regulator.sv ====
// Self-checking bench for the regulator: registers, loop and sleep.
// Assumes the regulator, its checker and the transducer model.
module tb_pid_regulator;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and bus signals, named as the ports.
  logic clk = 1'h0, rst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, outputOn;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  // Process value, transducer type, sleep pin and references.
  logic [11:0] processPct = 12'h000, freqRefIn = 12'h123;
  logic currentLoop = 1'h0, sleepCmdPin = 1'h0;
  logic [11:0] feedbackRaw, freqRefOut;
  int bad_count = 0, checks = 0;

  pid_regulator #(.TICK_CYC(10)) pid_regulator_i (.*);
  pid_transducer_model pid_transducer_model_i (.*);

  // Free running 50 MHz clock.
  initial begin
    forever #10 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch.
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One write; each channel is released at the edge that takes it.
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er = 2'h0);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  // One read, compared with the expected word and response.
  task automatic rd(logic [7:0] a, logic [31:0] exp, logic [1:0] er = 2'h0);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk("rdata", exp, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  // Waits a bounded time for an output to reach a value.
  task automatic waitRef(logic [11:0] exp, int lim);
    repeat (lim) begin
      @(posedge clk);
      if (freqRefOut === exp) break;
    end
    chk("freqRefOut", {20'h0, exp}, {20'h0, freqRefOut});
  endtask
  task automatic waitOn(logic exp, int lim);
    repeat (lim) begin
      @(posedge clk);
      if (outputOn === exp) break;
    end
    chk("outputOn", {31'h0, exp}, {31'h0, outputOn});
  endtask

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  // Main sequence: registers, loop arithmetic, sleep and wake, then the integral clamp.
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    rd(pid_pkg::OFS_FBSEL, 32'h1);
    rd(pid_pkg::OFS_KP, 32'h200);
    rd(8'h3c, 32'h0, pid_pkg::RESP_SLVERR);
    wr(pid_pkg::OFS_STAT, 32'h1, pid_pkg::RESP_SLVERR);
    rd(pid_pkg::OFS_MODE, 32'h0);
    wr(pid_pkg::OFS_FSRC, 32'h5);
    wr(pid_pkg::OFS_TI, 32'h0);
    wr(pid_pkg::OFS_KD, 32'h0);
    wr(pid_pkg::OFS_SETP, 32'h800);
    processPct <= 12'h7f0;
    waitRef(12'h123, 40);
    wr(pid_pkg::OFS_MODE, 32'h1);
    waitRef(12'h020, 40);
    wr(pid_pkg::OFS_KP, 32'h100);
    waitRef(12'h010, 40);
    wr(pid_pkg::OFS_MODE, 32'h3);
    waitRef(12'h000, 40);
    processPct <= 12'h810;
    waitRef(12'h010, 40);
    wr(pid_pkg::OFS_MODE, 32'hb);
    waitRef(12'h810, 40);
    wr(pid_pkg::OFS_FSRC, 32'h0);
    waitRef(12'h123, 40);
    currentLoop <= 1'h1;
    processPct <= 12'h7f8;
    wr(pid_pkg::OFS_FSRC, 32'h5);
    wr(pid_pkg::OFS_MODE, 32'h1);
    wr(pid_pkg::OFS_FBSEL, 32'h2);
    wr(pid_pkg::OFS_KP, 32'h200);
    waitRef(12'h010, 40);
    currentLoop <= 1'h0;
    processPct <= 12'h000;
    wr(pid_pkg::OFS_FBSEL, 32'h1);
    wr(pid_pkg::OFS_SLVL, 32'h100);
    wr(pid_pkg::OFS_SDLY, 32'h3);
    wr(pid_pkg::OFS_WLVL, 32'h200);
    wr(pid_pkg::OFS_WDLY, 32'h3);
    wr(pid_pkg::OFS_SLEEP, 32'h1);
    for (int i = 0; i < 4; i++) begin
      processPct <= i[0] ? 12'h000 : 12'h800;
      repeat (15) @(posedge clk);
    end
    chk("outputOn", 32'h1, {31'h0, outputOn});
    processPct <= 12'h800;
    waitOn(1'h0, 80);
    processPct <= 12'h000;
    repeat (15) @(posedge clk);
    chk("outputOn", 32'h0, {31'h0, outputOn});
    waitOn(1'h1, 80);
    wr(pid_pkg::OFS_SLEEP, 32'h2);
    sleepCmdPin <= 1'h1;
    waitOn(1'h0, 20);
    sleepCmdPin <= 1'h0;
    waitOn(1'h1, 20);
    wr(pid_pkg::OFS_SLEEP, 32'h0);
    processPct <= 12'h800;
    repeat (80) @(posedge clk);
    chk("outputOn", 32'h1, {31'h0, outputOn});
    wr(pid_pkg::OFS_TI, 32'h1);
    processPct <= 12'h7f8;
    waitRef(12'hfff, 3000);
    repeat (30) @(posedge clk);
    rd(pid_pkg::OFS_OUT, 32'hfff0_0fff);
    wr(pid_pkg::OFS_MODE, 32'h0);
    rd(pid_pkg::OFS_OUT, 32'h0);
    summarize();
  end
endmodule
